// [art_pkg.sv]
package art_pkg;
   // ------------------------------------------------------------
   // register addresses on the special function register port
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8e; // timer_clock_select
   localparam logic [7:0] ADDR_CONTROL = 8'hc8; // reload_timer_control
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca; // reload_low_byte
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb; // reload_high_byte
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc; // count_low_byte
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd; // count_high_byte
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00; // every register
   // ------------------------------------------------------------
   // control register bit positions
   // ------------------------------------------------------------
   localparam int CTL_HIGH_FLAG = 7; // high_overflow_flag
   localparam int CTL_LOW_FLAG = 6; // low_overflow_flag
   localparam int CTL_LOW_IRQ_EN = 5; // low_byte_irq_enable
   localparam int CTL_CAPTURE_EN = 4; // capture_enable
   localparam int CTL_SPLIT = 3; // split_mode_bit
   localparam int CTL_RUN = 2; // run_bit
   localparam int CTL_CAPTURE_SRC = 1; // capture_source_select
   localparam int CTL_EXT_SEL = 0; // external_clock_select
   // ------------------------------------------------------------
   // clock select register bit positions
   // ------------------------------------------------------------
   localparam int CKS_HIGH_SEL = 5; // high_byte_clock_select
   localparam int CKS_LOW_SEL = 4; // low_byte_clock_select
   localparam int CKS_PRESCALE_LSB = 0; // legacy_prescale_field low bit
   // ------------------------------------------------------------
   // cycle counts
   // ------------------------------------------------------------
   localparam int SYS_DIV = 12; // system clock divider
   localparam int EXT_DIV = 8; // external and capture divider
   localparam int SYS_DIV4 = 4; // prescale code 01
   localparam int SYS_DIV48 = 48; // prescale code 10
   localparam logic [1:0] PRE_DIV12 = 2'h0; // prescale codes
   localparam logic [1:0] PRE_DIV4 = 2'h1;
   localparam logic [1:0] PRE_DIV48 = 2'h2;
   localparam logic [1:0] PRE_EXT8 = 2'h3;
   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic highFlag; // high_overflow_flag
      logic lowFlag; // low_overflow_flag
      logic lowIrqEn; // low_byte_irq_enable
      logic captureEn; // capture_enable
      logic split; // split_mode_bit
      logic run; // run_bit
      logic captureSrc; // capture_source_select
      logic extSel; // external_clock_select
   } art_control_type;
   typedef struct packed {
      logic write; // write strobe
      logic [7:0] addr; // register address
      logic [7:0] data; // write data
   } art_sfr_type;
endpackage

// [art_edge_div.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// synchronise a slow clock and divide its rising edges
// ------------------------------------------------------------
module art_edge_div
   import art_pkg::*;
#(
   parameter int DIV = EXT_DIV // edges per output pulse
)(
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic srcIn, // slow clock from another source
   output logic tick // one pulse per DIV rising edges
);
   // refuse a divider that could never wrap its counter
   if (DIV < 2)
   begin : g_bad_div
      $error("DIV must be at least 2");
   end
   localparam int CW = $clog2(DIV);
   logic syncA; // first stage, read only by syncB
   logic syncB; // second stage
   logic syncC; // previous value for edge detect
   logic [CW-1:0] cnt; // edge counter
   logic [CW-1:0] next_cnt;
   logic next_tick;
   // next count on each synchronised rising edge
   always_comb
   begin
      next_cnt = cnt;
      next_tick = 1'b0;
      if (syncB && !syncC)
      begin
         if (cnt == CW'(DIV - 1))
         begin
            next_cnt = '0;
            next_tick = 1'b1;
         end
         else
            next_cnt = cnt + 1'b1;
      end
   end
   // synchroniser and counter registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         syncA <= 1'b0;
         syncB <= 1'b0;
         syncC <= 1'b0;
         cnt <= '0;
         tick <= 1'b0;
      end
      else
      begin
         syncA <= srcIn;
         syncB <= syncA;
         syncC <= syncB;
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule
`default_nettype wire

// [art_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module art_timer
   import art_pkg::*;
(
   input wire logic clk, // system clock, 10 MHz
   input wire logic rst_b, // async reset, active low
   input wire art_sfr_type sfrIn, // register write port
   input wire logic [7:0] sfrRdAddr, // register read address
   output logic [7:0] sfrRdData, // registered read data
   input wire logic extClk, // external oscillator clock
   input wire logic rtcClk, // real-time clock
   input wire logic timerIrqEnable, // global timer irq enable
   output logic irq, // interrupt request, active high
   output logic legacyTick, // prescaled tick for legacy timers
   output logic captureEvent // one pulse per capture
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   art_control_type ctl, next_ctl; // control register
   logic [7:0] clkSel, next_clkSel; // clock select register
   logic [7:0] rlLow, next_rlLow; // reload low
   logic [7:0] rlHigh, next_rlHigh; // reload high
   logic [7:0] cntLow, next_cntLow; // count low
   logic [7:0] cntHigh, next_cntHigh; // count high
   logic [3:0] div12, next_div12; // system /12 divider
   logic [5:0] divPre, next_divPre; // legacy divider
   logic sys12Tick, next_sys12Tick; // one pulse every 12 clocks
   logic next_irq, next_legacyTick, next_captureEvent;
   logic [7:0] rdValue; // read multiplexer
   logic extTick; // synchronised ext/8 pulse
   logic rtcTick; // synchronised rtc/8 pulse
   // ------------------------------------------------------------
   // external clock dividers
   // ------------------------------------------------------------
   art_edge_div #(.DIV(EXT_DIV)) u_extDiv (
      .clk(clk),
      .rst_b(rst_b),
      .srcIn(extClk),
      .tick(extTick)
   );
   art_edge_div #(.DIV(EXT_DIV)) u_rtcDiv (
      .clk(clk),
      .rst_b(rst_b),
      .srcIn(rtcClk),
      .tick(rtcTick)
   );
   // ------------------------------------------------------------
   // tick selection helper
   // ------------------------------------------------------------
   // choose a byte's count enable from its select bit
   function automatic logic pickTick(input logic sel, input logic ext,
                                     input logic s12, input logic alt);
      pickTick = sel ? 1'b1 : (ext ? alt : s12);
   endfunction
   // ------------------------------------------------------------
   // prescalers
   // ------------------------------------------------------------
   // system /12 and legacy prescale dividers
   always_comb
   begin
      next_div12 = (div12 == 4'(SYS_DIV - 1)) ? 4'h0 : div12 + 4'h1;
      next_sys12Tick = (div12 == 4'(SYS_DIV - 1));
      next_divPre = divPre + 6'h01;
      next_legacyTick = 1'b0;
      case (clkSel[CKS_PRESCALE_LSB +: 2])
         PRE_DIV12: next_legacyTick = sys12Tick;
         PRE_DIV4:
         begin
            if (divPre >= 6'(SYS_DIV4 - 1))
               next_divPre = 6'h00;
            next_legacyTick = (divPre == 6'(SYS_DIV4 - 1));
         end
         PRE_DIV48:
         begin
            if (divPre >= 6'(SYS_DIV48 - 1))
               next_divPre = 6'h00;
            next_legacyTick = (divPre == 6'(SYS_DIV48 - 1));
         end
         default: next_legacyTick = extTick;
      endcase
   end
   // ------------------------------------------------------------
   // timer core and register writes
   // ------------------------------------------------------------
   logic lowEn, highEn, lowWrap, highWrap, capt, alt, altCapt;
   always_comb
   begin
      next_ctl = ctl;
      next_clkSel = clkSel;
      next_rlLow = rlLow;
      next_rlHigh = rlHigh;
      next_cntLow = cntLow;
      next_cntHigh = cntHigh;
      lowWrap = 1'b0;
      highWrap = 1'b0;
      // counting source for ext select; other source when capturing
      alt = extTick;
      if (ctl.captureEn && ctl.captureSrc)
         alt = rtcTick;
      altCapt = ctl.captureSrc ? extTick : rtcTick;
      capt = ctl.captureEn && altCapt;
      lowEn = pickTick(clkSel[CKS_LOW_SEL], ctl.extSel, sys12Tick, alt);
      highEn = pickTick(clkSel[CKS_HIGH_SEL], ctl.extSel, sys12Tick,
                        alt);
      // software writes first, hardware events override flags
      if (sfrIn.write)
      begin
         if (sfrIn.addr == ADDR_CONTROL)
            next_ctl = art_control_type'(sfrIn.data);
         else if (sfrIn.addr == ADDR_CLOCK_SELECT)
            next_clkSel = sfrIn.data;
         else if (sfrIn.addr == ADDR_RELOAD_LOW)
            next_rlLow = sfrIn.data;
         else if (sfrIn.addr == ADDR_RELOAD_HIGH)
            next_rlHigh = sfrIn.data;
         else if (sfrIn.addr == ADDR_COUNT_LOW)
            next_cntLow = sfrIn.data;
         else if (sfrIn.addr == ADDR_COUNT_HIGH)
            next_cntHigh = sfrIn.data;
      end
      if (!ctl.split)
      begin
         // one 16-bit counter on the low byte's clock
         if (ctl.run && lowEn)
         begin
            lowWrap = (cntLow == 8'hff);
            if (lowWrap && cntHigh == 8'hff)
            begin
               highWrap = 1'b1;
               next_cntLow = rlLow;
               next_cntHigh = rlHigh;
            end
            else
            begin
               next_cntLow = cntLow + 8'h01;
               next_cntHigh = cntHigh + {7'h00, lowWrap};
            end
         end
      end
      else
      begin
         // low byte always runs in split mode
         if (lowEn)
         begin
            lowWrap = (cntLow == 8'hff);
            next_cntLow = lowWrap ? rlLow : cntLow + 8'h01;
         end
         if (ctl.run && highEn)
         begin
            highWrap = (cntHigh == 8'hff);
            next_cntHigh = highWrap ? rlHigh : cntHigh + 8'h01;
         end
      end
      if (capt)
      begin
         next_rlLow = cntLow;
         next_rlHigh = cntHigh;
      end
      // set wins over a software clear in the same cycle
      if (highWrap || capt)
         next_ctl.highFlag = 1'b1;
      if (lowWrap)
         next_ctl.lowFlag = 1'b1;
      next_captureEvent = capt;
   end
   // ------------------------------------------------------------
   // interrupt and read data
   // ------------------------------------------------------------
   always_comb
   begin
      next_irq = timerIrqEnable && (next_ctl.highFlag ||
                 (next_ctl.lowFlag && next_ctl.lowIrqEn));
      if (sfrRdAddr == ADDR_CONTROL)
         rdValue = ctl;
      else if (sfrRdAddr == ADDR_CLOCK_SELECT)
         rdValue = clkSel;
      else if (sfrRdAddr == ADDR_RELOAD_LOW)
         rdValue = rlLow;
      else if (sfrRdAddr == ADDR_RELOAD_HIGH)
         rdValue = rlHigh;
      else if (sfrRdAddr == ADDR_COUNT_LOW)
         rdValue = cntLow;
      else if (sfrRdAddr == ADDR_COUNT_HIGH)
         rdValue = cntHigh;
      else
         rdValue = RESET_BYTE;
   end
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctl <= art_control_type'(RESET_BYTE);
         clkSel <= RESET_BYTE;
         rlLow <= RESET_BYTE;
         rlHigh <= RESET_BYTE;
         cntLow <= RESET_BYTE;
         cntHigh <= RESET_BYTE;
         div12 <= 4'h0;
         divPre <= 6'h00;
         sys12Tick <= 1'b0;
         irq <= 1'b0;
         legacyTick <= 1'b0;
         captureEvent <= 1'b0;
         sfrRdData <= RESET_BYTE;
      end
      else
      begin
         ctl <= next_ctl;
         clkSel <= next_clkSel;
         rlLow <= next_rlLow;
         rlHigh <= next_rlHigh;
         cntLow <= next_cntLow;
         cntHigh <= next_cntHigh;
         div12 <= next_div12;
         divPre <= next_divPre;
         sys12Tick <= next_sys12Tick;
         irq <= next_irq;
         legacyTick <= next_legacyTick;
         captureEvent <= next_captureEvent;
         sfrRdData <= rdValue;
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   // 16-bit wrap from all ones reloads both bytes and flags it
   a_wrap_reload: assert property (
      @(posedge clk) disable iff (!rst_b)
      (!ctl.split && ctl.run && lowEn && cntLow == 8'hff
       && cntHigh == 8'hff && !capt)
      |=> (ctl.highFlag && cntLow == $past(rlLow)
           && cntHigh == $past(rlHigh)))
      else $error("16-bit wrap did not reload");
   // low byte wrap flags in every mode
   a_low_flag_set: assert property (
      @(posedge clk) disable iff (!rst_b)
      lowWrap |=> ctl.lowFlag)
      else $error("low wrap did not set flag");
   // split low byte ignores the run bit
   a_split_low_runs: assert property (
      @(posedge clk) disable iff (!rst_b)
      (ctl.split && !ctl.run && lowEn && !sfrIn.write && cntLow != 8'hff)
      |=> cntLow == $past(cntLow) + 8'h01)
      else $error("split low byte did not count");
   // a stopped 16-bit timer keeps its high byte
   a_stopped_hold: assert property (
      @(posedge clk) disable iff (!rst_b)
      (!ctl.run && !ctl.split && !sfrIn.write) |=> $stable(cntHigh))
      else $error("stopped timer changed");
   // a stopped split high byte keeps its value
   a_split_high_hold: assert property (
      @(posedge clk) disable iff (!rst_b)
      (!ctl.run && ctl.split && !sfrIn.write) |=> $stable(cntHigh))
      else $error("stopped split high byte changed");
   // split high byte wrap reloads and flags
   a_split_high: assert property (
      @(posedge clk) disable iff (!rst_b)
      (ctl.split && ctl.run && highEn && cntHigh == 8'hff)
      |=> (ctl.highFlag && cntHigh == $past(rlHigh)))
      else $error("split high wrap wrong");
   // only a control write may drop the high flag
   a_flag_sticky: assert property (
      @(posedge clk) disable iff (!rst_b)
      (ctl.highFlag && !(sfrIn.write && sfrIn.addr == ADDR_CONTROL))
      |=> ctl.highFlag)
      else $error("high flag cleared by hardware");
   // a capture copies the count and flags it
   a_capture_copy: assert property (
      @(posedge clk) disable iff (!rst_b)
      capt |=> (rlLow == $past(cntLow) && rlHigh == $past(cntHigh)
                && ctl.highFlag && captureEvent))
      else $error("capture did not copy count");
   // the request follows the flags in the same clock they change
   a_irq_follow: assert property (
      @(posedge clk) disable iff (!rst_b)
      ##1 irq == $past(timerIrqEnable && (next_ctl.highFlag ||
             (next_ctl.lowFlag && next_ctl.lowIrqEn)), 1))
      else $error("irq does not follow flags");
   // an enabled low flag keeps the request raised
   a_low_irq: assert property (
      @(posedge clk) disable iff (!rst_b)
      (timerIrqEnable && ctl.lowFlag && ctl.lowIrqEn && !sfrIn.write)
      |=> irq)
      else $error("low flag did not raise irq");
   // system clock select counts on every clock
   a_sys_sel_count: assert property (
      @(posedge clk) disable iff (!rst_b)
      (!ctl.split && ctl.run && clkSel[CKS_LOW_SEL] && !sfrIn.write
       && cntLow != 8'hff)
      |=> cntLow == $past(cntLow) + 8'h01)
      else $error("system clock count missed");
   // divide by 12 tick: one high, eleven low
   a_sys12_period: assert property (
      @(posedge clk) disable iff (!rst_b)
      sys12Tick |=> !sys12Tick [*8] ##1 !sys12Tick ##1 !sys12Tick
      ##1 !sys12Tick ##1 sys12Tick)
      else $error("divide by 12 period wrong");
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import art_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observation signals
   // ------------------------------------------------------------
   logic clk = 1'b0; // system clock
   logic rst_b = 1'b0; // reset, active low
   art_sfr_type sfrIn = '0; // register write port
   logic [7:0] sfrRdAddr = 8'h00; // read address
   logic [7:0] sfrRdData; // read data
   logic extClk = 1'b0; // external oscillator, period 8 clk
   logic rtcClk = 1'b0; // real-time clock, period 10 clk
   logic timerIrqEnable = 1'b0; // global irq enable
   logic irq; // interrupt request
   logic legacyTick; // legacy prescaled tick
   logic captureEvent; // capture pulse
   int error_cnt = 0; // mismatches
   int checks = 0; // comparisons made
   int tickCnt = 0; // legacy ticks seen
   int capCnt = 0; // capture pulses seen
   int phase = 0; // source clock divider
   logic [7:0] rdv; // last read value
   logic [7:0] rdh; // second read value
   art_timer uut (.clk(clk), .rst_b(rst_b), .sfrIn(sfrIn),
      .sfrRdAddr(sfrRdAddr), .sfrRdData(sfrRdData), .extClk(extClk),
      .rtcClk(rtcClk), .timerIrqEnable(timerIrqEnable), .irq(irq),
      .legacyTick(legacyTick), .captureEvent(captureEvent));
   // ------------------------------------------------------------
   // clock, slow sources and pulse counters
   // ------------------------------------------------------------
   always #50 clk = ~clk;
   always @(posedge clk)
   begin
      phase <= phase + 1;
      if (phase % 4 == 3) extClk <= ~extClk;
      if (phase % 5 == 4) rtcClk <= ~rtcClk;
      tickCnt <= tickCnt + int'(legacyTick);
      capCnt <= capCnt + int'(captureEvent);
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // value must fall within lo..hi, an unknown fails
   task automatic near(input logic [15:0] seen, input int lo, input int hi);
      logic ok;
      ok = (seen >= lo) && (seen <= hi);
      chk({7'h00, ok}, 8'h01);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfrIn <= '{write: 1'b1, addr: a, data: d};
      @(posedge clk);
      sfrIn.write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sfrRdAddr <= a;
      repeat (2) @(posedge clk);
      #1 d = sfrRdData;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // reset values, read back, unmapped place
   task automatic t_regs;
      logic [7:0] map [7] = '{8'h8e, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h55};
      foreach (map[i])
      begin
         rd(map[i], rdv);
         chk(rdv, RESET_BYTE);
      end
      wr(8'hca, 8'ha5);
      wr(8'h55, 8'hff);
      rd(8'hca, rdv);
      chk(rdv, 8'ha5);
      rd(8'h55, rdv);
      chk(rdv, 8'h00);
   endtask
   // 16-bit wrap, reload, flags that persist, irq equation
   task automatic t_wrap16;
      @(posedge clk) timerIrqEnable <= 1'b1;
      wr(8'h8e, 8'h10);
      wr(8'hca, 8'h34);
      wr(8'hcb, 8'h12);
      wr(8'hcc, 8'hf0);
      wr(8'hcd, 8'hff);
      chk({7'h00, irq}, 8'h00);
      wr(8'hc8, 8'h04);
      idle(40);
      chk({7'h00, irq}, 8'h01);
      rd(8'hc8, rdv);
      chk(rdv, 8'hc4);
      rd(8'hcd, rdv);
      chk(rdv, 8'h12);
      idle(50);
      rd(8'hc8, rdv);
      chk(rdv, 8'hc4);
      wr(8'hc8, 8'h40);
      idle(2);
      chk({7'h00, irq}, 8'h00);
      wr(8'hc8, 8'h60);
      idle(2);
      chk({7'h00, irq}, 8'h01);
      @(posedge clk) timerIrqEnable <= 1'b0;
      idle(2);
      chk({7'h00, irq}, 8'h00);
      @(posedge clk) timerIrqEnable <= 1'b1;
      wr(8'hc8, 8'h00);
   endtask
   // split mode: low free runs, high gated by run
   task automatic t_split;
      wr(8'h8e, 8'h30);
      wr(8'hca, 8'hf0);
      wr(8'hcb, 8'h80);
      wr(8'hcc, 8'hfc);
      wr(8'hcd, 8'hfe);
      wr(8'hc8, 8'h08);
      idle(10);
      rd(8'hcd, rdv);
      chk(rdv, 8'hfe);
      rd(8'hc8, rdv);
      chk(rdv, 8'h48);
      rd(8'hcc, rdv);
      near({8'h00, rdv}, 8'hf0, 8'hff);
      wr(8'hc8, 8'h0c);
      idle(20);
      rd(8'hc8, rdv);
      chk(rdv, 8'hcc);
      rd(8'hcd, rdv);
      near({8'h00, rdv}, 8'h80, 8'h9f);
      chk({7'h00, irq}, 8'h01);
      wr(8'hc8, 8'h00);
   endtask
   // count clocks: system_clock/12, ext/8 plain or under rtc capture, rtc/8 under ext capture
   task automatic t_rate(input logic [7:0] cks, input logic [7:0] ctl,
      input int lo, input int hi);
      wr(8'h8e, cks);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc8, ctl);
      idle(240);
      wr(8'hc8, 8'h00);
      rd(8'hcc, rdv);
      rd(8'hcd, rdh);
      near({rdh, rdv}, lo, hi);
   endtask
   // capture pulse rate and copy into reload
   task automatic t_capture(input logic [7:0] ctl, input int lo, input int hi);
      int c0;
      wr(8'h8e, 8'h10);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      c0 = capCnt;
      wr(8'hc8, ctl);
      idle(400);
      near(16'(capCnt - c0), lo, hi);
      rd(8'hc8, rdv);
      chk(rdv, 8'hc0 | ctl);
      wr(8'hc8, 8'h00);
      rd(8'hca, rdv);
      rd(8'hcb, rdh);
      near({rdh, rdv}, 1, 700);
   endtask
   // legacy prescale codes 00..11
   task automatic t_legacy;
      int expv [4] = '{40, 120, 10, 7};
      int t0;
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h8e, 8'(c));
         t0 = tickCnt;
         idle(480);
         near(16'(tickCnt - t0), expv[c] - 1, expv[c] + 1);
      end
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_wrap16;
      t_split;
      t_rate(8'h00, 8'h04, 18, 22);
      t_rate(8'h00, 8'h05, 3, 4);
      t_rate(8'h00, 8'h15, 3, 4);
      t_rate(8'h00, 8'h17, 2, 4);
      t_capture(8'h14, 4, 6);
      t_capture(8'h16, 5, 7);
      t_legacy;
      wrap_up;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      wrap_up;
   end
endmodule
`default_nettype wire
